// [rtl/css_switcher.sv]
// clock source switcher: protected control register, switch sequence, sleep handling
// assumes oscillator ready/lock signals synchronous to CLK and apb master on CLK
//Contract
//- high byte writable only after keys 78h then 9Ah, next write sets source
//- low byte writable only after keys 46h then 57h, next write sets request
//- next source field sits at control bits 10 to 8
//- setting request bit 0 starts the switch sequence
//- current source field at bits 14 to 12 is read-only
//- equal current and next sources: clear request and abort
//- valid switch clears lock status bit 5 and fail flag bit 3
//- enable target oscillator; for crystal wait for startup timer expiry
//- multiplier sources wait for lock bit set
//- count ten new-clock cycles then switch the system clock
//- on success clear request and copy next into current
//- turn old source off except rc for watchdog/monitor and enabled secondary
//- cpu keeps running during switch; avoid timing-sensitive code
//- config word two bits 12 to 11 select secondary oscillator power mode
//- sleep shuts down the system clock source oscillator
//- low power rc runs in sleep with watchdog on; watchdog cleared first
//- fail-safe monitor inactive during sleep
//- wake on enabled interrupt, reset or watchdog timeout
//- wake resumes with the same clock source
//- switch-monitor config bit at one disables switching and monitor
//- switching disabled holds request zero and next has no effect
//
// The address map and the APB register port were left to the implementer.
module css_switcher
	import css_pkg::*;
#(
	parameter int SRC_COUNT = 6
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [7:0] OSC_READY,
	input wire logic PLL_LOCK,
	input wire logic SLEEP_REQ,
	input wire logic WAKE_EVENT,
	input wire logic [2:0] RESET_SOURCE,
	output logic [7:0] OSC_ENABLE,
	output logic [2:0] SYSCLK_SEL,
	output logic MONITOR_ACTIVE,
	output logic WDT_CLEAR,
	output logic [1:0] SECONDARY_OSC_POWER_SEL,
	output logic IN_SLEEP
);
	// the source codes and the enable vector assume between six and eight sources
	if (SRC_COUNT < 6 || SRC_COUNT > 8) begin : g_bad_count
		$error("source count out of range");
	end

	// the settle counter must reach its end value and the fields must not overlap
	if (CSS_SETTLE_CYC == 4'd0) begin : g_bad_settle
		$error("settle count must be nonzero");
	end
	if (CSS_CUR_LSB < CSS_NEXT_LSB + 3) begin : g_bad_fields
		$error("source fields overlap");
	end

	// code validity, used by the next source write path
	function automatic logic src_valid(input logic [2:0] code);
		src_valid = (int'(code) < SRC_COUNT);
	endfunction

	// one step of a two-byte key detector; anything off the key path re-arms it
	function automatic logic [1:0] key_step(input logic [1:0] key, input logic [7:0] wbyte,
		input logic [7:0] key_a, input logic [7:0] key_b);
		key_step = 2'd0;
		if (key == 2'd0 && wbyte == key_a) begin
			key_step = 2'd1;
		end else if (key == 2'd1 && wbyte == key_b) begin
			key_step = 2'd2;
		end
	endfunction
	function automatic logic src_pll(input logic [2:0] code);
		src_pll = (code == CSS_SRC_FAST_RC_WITH_MULTIPLIER) || (code == CSS_SRC_PRIPLL);
	endfunction
	function automatic logic [7:0] onehot(input logic [2:0] code);
		onehot = 8'h01 << code;
	endfunction

	css_state_t state, next_state;
	logic [2:0] cur_src, next_cur_src;
	logic [2:0] nxt_src, next_nxt_src;
	logic swreq, next_swreq;
	logic lock_st, next_lock_st;
	logic cfail, next_cfail;
	logic secondary_osc_on, next_secondary_osc_on;
	logic [15:0] cfg, next_cfg;
	logic [1:0] key_hi, next_key_hi;
	logic [1:0] key_lo, next_key_lo;
	logic [3:0] settle, next_settle;
	logic [7:0] osc_en, next_osc_en;
	logic [31:0] rdata, next_rdata;
	logic ready, next_ready;
	logic slverr, next_slverr;
	logic wdt_clr, next_wdt_clr;
	// status outputs kept in their own flops
	logic in_sleep, next_in_sleep;
	logic mon_act, next_mon_act;
	// decoded access strobes and protected-byte write strobes, plus the switch enable and the keep mask
	logic ctrl_wr;
	logic hi_open;
	logic lo_open;
	logic sel_valid;
	logic wr_acc;
	logic sw_enabled;
	logic [7:0] keep_mask;

	// an access completes in its first access cycle, so writes land at the setup edge
	assign sel_valid = PSEL && !PENABLE;
	assign wr_acc = sel_valid && PWRITE;
	assign ctrl_wr = wr_acc && (PADDR == CSS_OSC_CTRL_OFF);
	// a byte opens only for the one write that follows its second key
	assign hi_open = ctrl_wr && PSTRB[1] && (key_hi == 2'd2);
	assign lo_open = ctrl_wr && PSTRB[0] && (key_lo == 2'd2);
	assign sw_enabled = !cfg[CSS_CFG_SWMON_BIT];

	// sources that must stay on regardless of selection
	always_comb begin
		keep_mask = 8'h00;
		if (cfg[CSS_CFG_WDT_BIT] || sw_enabled) begin
			keep_mask = keep_mask | onehot(CSS_SRC_LOW_POWER_RC_OSC);
		end
		if (secondary_osc_on) begin
			keep_mask = keep_mask | onehot(CSS_SRC_SEC);
		end
	end

	// key detectors: every write re-arms both unless it advances one
	always_comb begin
		next_key_hi = key_hi;
		next_key_lo = key_lo;
		if (wr_acc) begin
			next_key_hi = 2'd0;
			next_key_lo = 2'd0;
			if (ctrl_wr && PSTRB[1] && key_hi != 2'd2) begin
				next_key_hi = key_step(key_hi, PWDATA[15:8], CSS_KEY_HI_A, CSS_KEY_HI_B);
			end
			if (ctrl_wr && PSTRB[0] && key_lo != 2'd2) begin
				next_key_lo = key_step(key_lo, PWDATA[7:0], CSS_KEY_LO_A, CSS_KEY_LO_B);
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			key_hi <= 2'd0;
			key_lo <= 2'd0;
		end else begin
			key_hi <= next_key_hi;
			key_lo <= next_key_lo;
		end
	end

	// register port: every access is answered in the cycle after its setup edge
	always_comb begin
		next_rdata = rdata;
		next_ready = 1'b0;
		next_slverr = 1'b0;
		if (sel_valid) begin
			next_ready = 1'b1;
			next_rdata = 32'h0000_0000;
			case (PADDR)
				CSS_OSC_CTRL_OFF: begin
					// current source is reported here and has no write path
					next_rdata[CSS_CUR_LSB +: 3] = cur_src;
					next_rdata[CSS_NEXT_LSB +: 3] = nxt_src;
					next_rdata[CSS_LOCK_BIT] = lock_st;
					next_rdata[CSS_CFAIL_BIT] = cfail;
					next_rdata[CSS_SECONDARY_OSC_ON_BIT] = secondary_osc_on;
					next_rdata[CSS_SWREQ_BIT] = swreq;
				end
				CSS_STATUS_OFF: begin
					next_rdata[4:0] = state;
					next_rdata[15:8] = osc_en;
				end
				CSS_CFG_OFF: next_rdata[15:0] = cfg;
				// unmapped offsets answer with an error and change nothing but the key detectors
				default: next_slverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata <= 32'h0000_0000;
			ready <= 1'b0;
			slverr <= 1'b0;
		end else begin
			rdata <= next_rdata;
			ready <= next_ready;
			slverr <= next_slverr;
		end
	end

	always_comb begin
		next_state = state;
		next_cur_src = cur_src;
		next_nxt_src = nxt_src;
		next_swreq = swreq;
		next_lock_st = PLL_LOCK;
		next_cfail = cfail;
		next_secondary_osc_on = secondary_osc_on;
		next_cfg = cfg;
		next_settle = settle;
		next_osc_en = osc_en;
		next_wdt_clr = 1'b0;
		if (hi_open) begin
			// next source accepted only when valid and enabled
			if (sw_enabled && src_valid(PWDATA[CSS_NEXT_LSB +: 3])) begin
				next_nxt_src = PWDATA[CSS_NEXT_LSB +: 3];
			end
		end
		if (lo_open) begin
			next_secondary_osc_on = PWDATA[CSS_SECONDARY_OSC_ON_BIT];
			// software may only clear the fail flag, never set it
			if (!PWDATA[CSS_CFAIL_BIT]) begin
				next_cfail = 1'b0;
			end
			// request set only while switching is enabled and no switch runs
			if (PWDATA[CSS_SWREQ_BIT] && sw_enabled && state == CSS_IDLE) begin
				next_swreq = 1'b1;
				next_state = CSS_START;
			end
		end
		if (wr_acc && PADDR == CSS_CFG_OFF) begin
			// configuration word image, written by the loader
			next_cfg = PWDATA[15:0];
		end
		case (state)
			CSS_IDLE: begin
				// sleep stops the system oscillator, keeps selection
				if (SLEEP_REQ) begin
					next_wdt_clr = cfg[CSS_CFG_WDT_BIT];
					next_state = CSS_SLEEP;
				end
			end
			CSS_START: begin
				if (nxt_src == cur_src) begin
					next_swreq = 1'b0;
					next_state = CSS_IDLE;
				end else begin
					// clear status at a valid start
					next_lock_st = 1'b0;
					next_cfail = 1'b0;
					next_osc_en = osc_en | onehot(nxt_src);
					next_state = CSS_LOCKW;
				end
			end
			CSS_LOCKW: begin
				next_lock_st = PLL_LOCK;
				// wait for startup timer and multiplier lock
				if (OSC_READY[nxt_src] && (!src_pll(nxt_src) || PLL_LOCK)) begin
					next_settle = 4'd0;
					next_state = CSS_SETTLE;
				end
			end
			CSS_SETTLE: begin
				// ten cycles on the new clock before commit
				if (settle == CSS_SETTLE_CYC - 4'd1) begin
					next_cur_src = nxt_src;
					next_swreq = 1'b0;
					next_osc_en = onehot(nxt_src) | keep_mask;
					next_state = CSS_IDLE;
				end else begin
					next_settle = settle + 4'd1;
				end
			end
			CSS_SLEEP: begin
				// only the low power rc survives if watchdog is on
				next_osc_en = cfg[CSS_CFG_WDT_BIT] ? onehot(CSS_SRC_LOW_POWER_RC_OSC) : 8'h00;
				// wake on interrupt or watchdog timeout
				if (WAKE_EVENT) begin
					next_osc_en = onehot(cur_src) | keep_mask;
					next_state = CSS_IDLE;
				end
			end
			default: next_state = CSS_IDLE;
		endcase
		// request held at zero while switching is disabled
		if (!sw_enabled) begin
			next_swreq = 1'b0;
		end
	end


	// the switch never stalls the register port
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= CSS_IDLE;
			cur_src <= CSS_SRC_RESET;
			nxt_src <= CSS_SRC_RESET;
			swreq <= 1'b0;
			lock_st <= 1'b0;
			cfail <= 1'b0;
			secondary_osc_on <= 1'b0;
			cfg <= CSS_CFG_RESET;
			settle <= 4'd0;
			osc_en <= CSS_OSC_EN_RESET;
			wdt_clr <= 1'b0;
		end else begin
			state <= next_state;
			cur_src <= next_cur_src;
			nxt_src <= next_nxt_src;
			swreq <= next_swreq;
			lock_st <= next_lock_st;
			cfail <= next_cfail;
			secondary_osc_on <= next_secondary_osc_on;
			cfg <= next_cfg;
			settle <= next_settle;
			osc_en <= next_osc_en;
			wdt_clr <= next_wdt_clr;
		end
	end

	// reset source strap is taken by the loader through the config path; kept for future use
	logic [2:0] unused_reset_src;
	assign unused_reset_src = RESET_SOURCE;

	// status outputs come from the next values, so they track the state flops
	always_comb begin
		next_in_sleep = (next_state == CSS_SLEEP);
		next_mon_act = !next_cfg[CSS_CFG_SWMON_BIT] && !next_in_sleep;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			in_sleep <= 1'b0;
			mon_act <= 1'b0;
		end else begin
			in_sleep <= next_in_sleep;
			mon_act <= next_mon_act;
		end
	end

	assign PRDATA = rdata;
	assign PREADY = ready;
	assign PSLVERR = slverr;
	assign OSC_ENABLE = osc_en;
	assign SYSCLK_SEL = cur_src;
	// monitor off in sleep or when disabled
	assign MONITOR_ACTIVE = mon_act;
	assign WDT_CLEAR = wdt_clr;
	assign SECONDARY_OSC_POWER_SEL = cfg[CSS_CFG_SOSCPW_LSB +: 2];
	assign IN_SLEEP = in_sleep;
endmodule

// [rtl/css_pkg.sv]
// package for the clock source switcher: register layout, keys, source codes, timing
// assumes a single 100 MHz clock domain and an apb register port
package css_pkg;
	localparam logic [11:0] CSS_OSC_CTRL_OFF = 12'h000;
	localparam logic [11:0] CSS_STATUS_OFF = 12'h004;
	localparam logic [11:0] CSS_CFG_OFF = 12'h008;
	// control register field positions
	localparam int CSS_SWREQ_BIT = 0;
	localparam int CSS_CFAIL_BIT = 3;
	localparam int CSS_LOCK_BIT = 5;
	localparam int CSS_NEXT_LSB = 8;
	localparam int CSS_CUR_LSB = 12;
	localparam int CSS_SECONDARY_OSC_ON_BIT = 1;
	// unlock keys
	localparam logic [7:0] CSS_KEY_HI_A = 8'h78;
	localparam logic [7:0] CSS_KEY_HI_B = 8'h9a;
	localparam logic [7:0] CSS_KEY_LO_A = 8'h46;
	localparam logic [7:0] CSS_KEY_LO_B = 8'h57;
	// source codes
	localparam logic [2:0] CSS_SRC_FRC = 3'h0;
	localparam logic [2:0] CSS_SRC_FAST_RC_WITH_MULTIPLIER = 3'h1;
	localparam logic [2:0] CSS_SRC_PRI = 3'h2;
	localparam logic [2:0] CSS_SRC_PRIPLL = 3'h3;
	localparam logic [2:0] CSS_SRC_SEC = 3'h4;
	localparam logic [2:0] CSS_SRC_LOW_POWER_RC_OSC = 3'h5;
	localparam logic [2:0] CSS_SRC_RESET = 3'h0;
	// fast rc and low power rc run out of reset
	localparam logic [7:0] CSS_OSC_EN_RESET = 8'h21;
	// settle count on the new clock
	localparam logic [3:0] CSS_SETTLE_CYC = 4'd10;
	// configuration bit positions
	localparam int CSS_CFG_SWMON_BIT = 0;
	localparam int CSS_CFG_WDT_BIT = 1;
	localparam int CSS_CFG_SOSCPW_LSB = 11;
	localparam logic [15:0] CSS_CFG_RESET = 16'h0001;
	typedef enum logic [4:0] {
		CSS_IDLE = 5'b00001,
		CSS_START = 5'b00010,
		CSS_LOCKW = 5'b00100,
		CSS_SETTLE = 5'b01000,
		CSS_SLEEP = 5'b10000
	} css_state_t;
	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] ready;
		logic pll_lock;
	} css_osc_t;
endpackage

// [sim/css_switcher_asserts.sv]
// port checker for the clock source switcher
// assumes zero-wait apb answers and one clock domain
module css_switcher_asserts
	import css_pkg::*;
#(
	parameter int SRC_COUNT = 6
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [11:0] PADDR,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [7:0] OSC_READY,
	input wire logic PLL_LOCK,
	input wire logic [7:0] OSC_ENABLE,
	input wire logic [2:0] SYSCLK_SEL,
	input wire logic MONITOR_ACTIVE,
	input wire logic IN_SLEEP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_moved;
		$changed(SYSCLK_SEL);
	endsequence
	// a short margin lets the enables settle after sleep entry
	sequence s_sleeping;
		IN_SLEEP [*3];
	endsequence
	a_ready_next: assert property (s_setup |=> PREADY)
		else $error("ready late");
	a_err_unmap: assert property (PREADY |-> PSLVERR == (PADDR[1:0] != 2'h0 || PADDR > 12'h008))
		else $error("slave error wrong");
	a_settle_ready: assert property (s_moved |-> ($past(OSC_READY, 10) & (8'h1 << SYSCLK_SEL)) != 8'h0)
		else $error("switched before settle");
	a_pll_locked: assert property (s_moved ##0 SYSCLK_SEL[0] && !SYSCLK_SEL[2] |-> PLL_LOCK)
		else $error("switched without lock");
	a_src_valid: assert property (SYSCLK_SEL < SRC_COUNT)
		else $error("invalid source");
	a_src_on: assert property (!IN_SLEEP [*4] |-> OSC_ENABLE[SYSCLK_SEL])
		else $error("active source off");
	a_sleep_off: assert property (s_sleeping ##0 SYSCLK_SEL == 3'h0 |-> !OSC_ENABLE[0])
		else $error("clock on in sleep");
	a_mon_sleep: assert property (IN_SLEEP |-> !MONITOR_ACTIVE)
		else $error("monitor in sleep");
	a_sel_hold: assert property (IN_SLEEP |=> $stable(SYSCLK_SEL))
		else $error("source moved in sleep");
endmodule
bind css_switcher css_switcher_asserts #(.SRC_COUNT(SRC_COUNT)) chk_u (.CLK, .RST_N, .PSEL,
	.PENABLE, .PADDR, .PREADY, .PSLVERR, .OSC_READY, .PLL_LOCK, .OSC_ENABLE, .SYSCLK_SEL,
	.MONITOR_ACTIVE, .IN_SLEEP);

// [sim/css_osc_model.sv]
// oscillator bank: each source is ready dly + 1 cycles after its enable
// assumes enables change only after rising clk edges
module css_osc_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] en,
	input wire logic [7:0] dly,
	output logic [7:0] ready = 8'h0,
	output logic lock = 1'h0
);
	int cnt[8] = '{default: 0};
	always @(posedge clk) begin
		for (int i = 0; i < 8; i++) begin
			// a dropped enable stops the source at once, so ready never lingers
			cnt[i] <= (rst_n && en[i]) ? cnt[i] + 1 : 0;
			ready[i] <= rst_n && en[i] && cnt[i] >= dly;
		end
		lock <= (en[1] && cnt[1] > dly + 4) || (en[3] && cnt[3] > dly + 4);
	end
endmodule

// [sim/test_css_switcher.sv]
// bench for the clock source switcher against an integer model
// assumes zero-wait apb answers and the oscillator bank model
module test_css_switcher
	import css_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'h0, RST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
	logic SLEEP_REQ = 1'h0, WAKE_EVENT = 1'h0, err;
	logic [11:0] PADDR = 12'h0;
	logic [31:0] PWDATA = 32'h0, rd;
	logic [3:0] PSTRB = 4'h0;
	logic [7:0] dly = 8'h2;
	wire logic [31:0] PRDATA;
	wire logic PREADY, PSLVERR, PLL_LOCK, MONITOR_ACTIVE, IN_SLEEP;
	wire logic [7:0] OSC_READY, OSC_ENABLE;
	wire logic [2:0] SYSCLK_SEL;
	wire logic [1:0] SECONDARY_OSC_POWER_SEL;
	wire logic WDT_CLEAR;
	int num_errors = 0, n_checks = 0, cur = 0, nxt = 0, sw_on = 0, i, n_wdt = 0;
	int q[$] = '{2, 0, 4, 5, 1, 0, 3, 3, 0};
	always #5 CLK = ~CLK;
	// the clear is a one-cycle pulse, so count it where it happens
	always @(posedge CLK)
		if (WDT_CLEAR === 1'h1)
			n_wdt <= n_wdt + 1;
	css_switcher dut_u (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
		.PRDATA, .PREADY, .PSLVERR, .OSC_READY, .PLL_LOCK, .SLEEP_REQ, .WAKE_EVENT,
		.RESET_SOURCE(3'h0), .OSC_ENABLE, .SYSCLK_SEL, .MONITOR_ACTIVE, .WDT_CLEAR,
		.SECONDARY_OSC_POWER_SEL, .IN_SLEEP);
	css_osc_model osc_u (.clk(CLK), .rst_n(RST_N), .en(OSC_ENABLE), .dly(dly),
		.ready(OSC_READY), .lock(PLL_LOCK));
	task automatic results();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic hang();
		num_errors++;
		results();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k = 0;
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= s;
		@(posedge CLK);
		PENABLE <= 1'h1;
		do begin
			@(posedge CLK);
			k++;
		end while (PREADY !== 1'h1 && k < 9);
		if (PREADY !== 1'h1)
			hang();
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	task automatic prot(input int ln, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] v);
		// keys and data go out in consecutive transfers, nothing in between
		apb(1'h1, CSS_OSC_CTRL_OFF, 32'(a) << (8 * ln), 4'h1 << ln);
		apb(1'h1, CSS_OSC_CTRL_OFF, 32'(b) << (8 * ln), 4'h1 << ln);
		apb(1'h1, CSS_OSC_CTRL_OFF, 32'(v) << (8 * ln), 4'h1 << ln);
	endtask
	task automatic ctrl();
		apb(1'h0, CSS_OSC_CTRL_OFF, 32'h0, 4'h0);
		chk(32'(rd[14:12]), 32'(cur));
		// the request bit reads zero once the switch has had time to finish
		chk(32'(rd[0]), 32'h0);
		if (sw_on && (cur == 1 || cur == 3))
			chk(32'(rd[5]), 32'h1);
		if (sw_on)
			chk(32'(rd[10:8]), 32'(nxt));
		chk(32'(OSC_ENABLE), 32'h20 | (32'h1 << cur));
	endtask
	task automatic go(input int t);
		dly <= 8'($urandom_range(0, 20));
		prot(1, CSS_KEY_HI_A, CSS_KEY_HI_B, 8'(t));
		prot(0, CSS_KEY_LO_A, CSS_KEY_LO_B, 8'h1);
		nxt = t;
		if (sw_on)
			cur = t;
		for (i = 0; i < 400 && SYSCLK_SEL !== 3'(cur); i++)
			@(posedge CLK);
		if (i == 400)
			hang();
		chk(32'(SYSCLK_SEL), 32'(cur));
		ctrl();
	endtask
	initial begin
		void'($urandom(32'hf3be));
		repeat (20) @(posedge CLK);
		RST_N <= 1'h1;
		ctrl();
		apb(1'h0, CSS_CFG_OFF, 32'h0, 4'h0);
		chk(rd, 32'(CSS_CFG_RESET));
		apb(1'h0, 12'h00c, 32'h0, 4'h0);
		chk(32'(err), 32'h1);
		go(2);
		$display("reset and locked test done");
		for (i = 0; i < 4; i++) begin
			apb(1'h1, CSS_CFG_OFF, 32'h2 | (i << 11), 4'hf);
			chk(32'(SECONDARY_OSC_POWER_SEL), i);
		end
		sw_on = 1;
		foreach (q[j])
			go(q[j]);
		// a random second key below the right one must leave the source field alone
		prot(1, CSS_KEY_HI_A, 8'($urandom_range(0, 8'h99)), 8'h4);
		ctrl();
		$display("switch test done");
		SLEEP_REQ <= 1'h1;
		for (i = 0; i < 50 && OSC_ENABLE[0] !== 1'h0; i++)
			@(posedge CLK);
		SLEEP_REQ <= 1'h0;
		if (i == 50)
			hang();
		chk({IN_SLEEP, MONITOR_ACTIVE, OSC_ENABLE[5], OSC_ENABLE[0]}, 32'ha);
		chk(32'(n_wdt), 32'h1);
		WAKE_EVENT <= 1'h1;
		for (i = 0; i < 50 && IN_SLEEP !== 1'h0; i++)
			@(posedge CLK);
		WAKE_EVENT <= 1'h0;
		if (i == 50)
			hang();
		ctrl();
		chk(32'(MONITOR_ACTIVE), 32'h1);
		$display("sleep test done");
		results();
	end
endmodule
